// >>> spi_phy_pkg.sv
/*
  Constants shared by the SPI slave physical layer: word layout, parity
  position, edge-count check and reset values of the answer path.
  Assumes nothing of its surroundings.
*/
package spi_phy_pkg;

  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int PAYLOAD_W = 15;
  localparam int PARITY_POS = 0;
  localparam int MSB_POS = 15;
  // Error notification flag inside the answer word
  localparam int ERROR_NOTIFY_BIT = 15;
  // Low count bits that must be zero for a whole number of words
  localparam int WORD_CNT_BITS = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  // Zero payload with its odd parity bit set
  localparam logic [15:0] RESET_ANSWER = 16'h0001;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [3:0] WORD_CNT_ZERO = 4'h0;

  // Frame tracking in the system clock domain
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FRAME,
    ST_SETTLE,
    ST_CHECK
  } frame_state_t;

endpackage

// >>> spi_slave_phy.sv
/*
  SPI slave physical layer: 16-bit words, MSB first, odd parity in the
  LSB, daisy-chain pass-through, frame checking at deselect.
  Assumes spi_clk is the master's serial clock, stopped while deselected;
  clk_sys is the local oscillator clock; the decoder behind this block
  answers each request with answer_valid before the next frame starts.
*/
`timescale 1ns/100ps
`default_nettype none

module spi_slave_phy
  import spi_phy_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic spi_clk,
  input wire logic chip_select_low,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  input wire logic parity_check_enable,
  input wire logic [14:0] answer_payload,
  input wire logic answer_valid,
  input wire logic [14:0] status_payload,
  input wire logic error_clear,
  output logic [15:0] request_word,
  output logic request_valid,
  output logic spi_error_pulse,
  output logic spi_error_sticky_flag
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Appends odd parity to a payload
  function automatic logic [15:0] with_parity(input logic [14:0] pl);
    with_parity = {pl, ~(^pl)};
  endfunction

  // ---------------------------------------------------------------
  // Link side: rising edges
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] rise_cnt;
  logic [CNT_W-1:0] next_rise_cnt;
  logic [15:0] tx_shift;
  logic [15:0] next_tx_shift;
  logic tx_bit;
  logic next_tx_bit;
  logic first_rise;
  logic [15:0] answer;
  logic [15:0] rx_shift;
  logic [CNT_W-1:0] fall_cnt;
  logic [CNT_W-1:0] next_fall_cnt;
  logic [15:0] next_rx_shift;
  logic [WORD_CNT_BITS-1:0] bit_pos;
  logic [WORD_CNT_BITS-1:0] next_bit_pos;

  // Output shifter; bit position restarts each frame, since the
  // free-running edge count may be off word after a cut frame
  always_comb begin
    logic [15:0] src;
    logic [WORD_CNT_BITS-1:0] idx;
    src = tx_shift;
    idx = first_rise ? WORD_CNT_ZERO : bit_pos;
    next_rise_cnt = rise_cnt;
    next_tx_shift = tx_shift;
    next_tx_bit = tx_bit;
    next_bit_pos = bit_pos;
    if (!chip_select_low) begin
      next_rise_cnt = rise_cnt + 1'b1;
      next_bit_pos = idx + 1'b1;
      if (first_rise) begin
        src = answer;
      end
      next_tx_bit = src[MSB_POS];
      next_tx_shift = {src[14:0], 1'b0};
      // word done: received word goes out next
      if (idx == '1) begin
        next_tx_shift = rx_shift;
      end
    end
  end

  // Async reset only: spi_clk may be stopped while sys_rst is applied
  always_ff @(posedge spi_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rise_cnt <= '0;
      tx_shift <= RESET_WORD;
      tx_bit <= 1'b0;
      bit_pos <= WORD_CNT_ZERO;
    end else begin
      rise_cnt <= next_rise_cnt;
      tx_shift <= next_tx_shift;
      tx_bit <= next_tx_bit;
      bit_pos <= next_bit_pos;
    end
  end

  // high select marks next edge as first
  always_ff @(posedge spi_clk or posedge chip_select_low or
              posedge sys_rst) begin
    if (chip_select_low || sys_rst) begin
      first_rise <= 1'b1;
    end else begin
      first_rise <= 1'b0;
    end
  end

  assign serial_out = tx_bit;

  // ---------------------------------------------------------------
  // Link side: falling edges
  // ---------------------------------------------------------------
  // Input shifter and falling edge count
  always_comb begin
    next_fall_cnt = fall_cnt;
    next_rx_shift = rx_shift;
    // data taken on clock edge only
    if (!chip_select_low) begin
      next_fall_cnt = fall_cnt + 1'b1;
      next_rx_shift = {rx_shift[14:0], serial_in};
    end
  end

  always_ff @(negedge spi_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fall_cnt <= '0;
      rx_shift <= RESET_WORD;
    end else begin
      fall_cnt <= next_fall_cnt;
      rx_shift <= next_rx_shift;
    end
  end

  // ---------------------------------------------------------------
  // System side: select filter and crossings
  // ---------------------------------------------------------------
  logic cs_s1, cs_s2, cs_prev, cs_filt;
  logic next_cs_filt;
  logic [CNT_W-1:0] rc_s1, rc_s2, fc_s1, fc_s2;
  logic [15:0] rx_s1, rx_s2;

  always_comb begin
    next_cs_filt = cs_filt;
    if (cs_s2 == cs_prev) begin
      next_cs_filt = cs_s2;
    end
  end

  // Counts and word only move inside a frame, so they are quiet
  // when read after deselect; plain two-stage sync is enough there
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_prev <= 1'b1;
      cs_filt <= 1'b1;
      rc_s1 <= '0;
      rc_s2 <= '0;
      fc_s1 <= '0;
      fc_s2 <= '0;
      rx_s1 <= RESET_WORD;
      rx_s2 <= RESET_WORD;
    end else begin
      cs_s1 <= chip_select_low;
      cs_s2 <= cs_s1;
      cs_prev <= cs_s2;
      cs_filt <= next_cs_filt;
      rc_s1 <= rise_cnt;
      rc_s2 <= rc_s1;
      fc_s1 <= fall_cnt;
      fc_s2 <= fc_s1;
      rx_s1 <= rx_shift;
      rx_s2 <= rx_s1;
    end
  end

  // ---------------------------------------------------------------
  // System side: frame check and answer
  // ---------------------------------------------------------------
  frame_state_t state, next_state;
  logic [CNT_W-1:0] rise_base, fall_base;
  logic [CNT_W-1:0] next_rise_base, next_fall_base;
  logic [15:0] next_answer, next_request_word;
  logic next_request_valid, next_error_pulse, next_sticky, next_out_en;

  always_comb begin
    logic [CNT_W-1:0] d_rise;
    logic [CNT_W-1:0] d_fall;
    logic bad;
    logic [14:0] err_pl;
    err_pl = status_payload;
    d_rise = rc_s2 - rise_base;
    d_fall = fc_s2 - fall_base;
    bad = 1'b0;
    next_state = state;
    next_rise_base = rise_base;
    next_fall_base = fall_base;
    next_answer = answer;
    next_request_word = request_word;
    next_request_valid = 1'b0;
    next_error_pulse = 1'b0;
    next_sticky = spi_error_sticky_flag;
    next_out_en = ~next_cs_filt;
    if (answer_valid && state == ST_IDLE) begin
      next_answer = with_parity(answer_payload);
    end
    unique case (state)
      ST_IDLE: begin
        if (!cs_filt) begin
          next_rise_base = rc_s2;
          next_fall_base = fc_s2;
          next_state = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (cs_filt) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        next_state = ST_CHECK;
      end
      ST_CHECK: begin
        // edge counts must match in whole words
        if (d_rise != d_fall || d_rise == '0 ||
            d_rise[WORD_CNT_BITS-1:0] != WORD_CNT_ZERO) begin
          bad = 1'b1;
        end
        // odd parity over the whole word
        if (parity_check_enable && !(^rx_s2)) begin
          bad = 1'b1;
        end
        if (bad) begin
          next_error_pulse = 1'b1;
          next_sticky = 1'b1;
          err_pl[ERROR_NOTIFY_BIT-1] = 1'b1;
          next_answer = with_parity(err_pl);
        end else begin
          next_request_word = rx_s2;
          next_request_valid = 1'b1;
        end
        next_state = ST_IDLE;
      end
    endcase
    // Set wins over a clear in the same cycle
    if (error_clear && !next_error_pulse) begin
      next_sticky = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      rise_base <= '0;
      fall_base <= '0;
      answer <= RESET_ANSWER;
      request_word <= RESET_WORD;
      request_valid <= 1'b0;
      spi_error_pulse <= 1'b0;
      spi_error_sticky_flag <= 1'b0;
      serial_out_en <= 1'b0;
    end else begin
      state <= next_state;
      rise_base <= next_rise_base;
      fall_base <= next_fall_base;
      answer <= next_answer;
      request_word <= next_request_word;
      request_valid <= next_request_valid;
      spi_error_pulse <= next_error_pulse;
      spi_error_sticky_flag <= next_sticky;
      serial_out_en <= next_out_en;
    end
  end

endmodule // spi_slave_phy

`default_nettype wire

// >>> spi_phy_chk.sv
/* Concurrent checks on the SPI slave phy top-level ports.
   Assumes one clk_sys domain with synchronous active-high sys_rst. */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module spi_phy_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chip_select_low,
  input wire logic serial_out_en,
  input wire logic parity_check_enable,
  input wire logic error_clear,
  input wire logic [15:0] request_word,
  input wire logic request_valid,
  input wire logic spi_error_pulse,
  input wire logic spi_error_sticky_flag
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Select filter is a few cycles, so eight cycles is a safe margin
  chk_oe_idle: assert property (chip_select_low [*8] |-> !serial_out_en)
    else $error("output driven while deselected");
  chk_oe_busy: assert property (!chip_select_low [*8] |-> serial_out_en)
    else $error("output off while selected");
  chk_valid_one: assert property (request_valid |=> !request_valid)
    else $error("request strobe longer than one cycle");
  chk_result_idle: assert property ((request_valid || spi_error_pulse)
    |-> chip_select_low)
    else $error("frame result while selected");
  chk_sticky_set: assert property (spi_error_pulse
    |-> ##[0:1] spi_error_sticky_flag)
    else $error("error flag not set");
  chk_sticky_clr: assert property ($fell(spi_error_sticky_flag)
    |-> $past(error_clear))
    else $error("error flag dropped without clear");
  chk_sticky_hold: assert property (spi_error_sticky_flag && !error_clear
    |=> spi_error_sticky_flag)
    else $error("error flag lost");
  chk_parity_ok: assert property (request_valid && $past(parity_check_enable)
    |-> ^request_word)
    else $error("word with even parity passed on");
endmodule // spi_phy_chk
bind spi_slave_phy spi_phy_chk i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .chip_select_low(chip_select_low), .serial_out_en(serial_out_en),
  .parity_check_enable(parity_check_enable), .error_clear(error_clear),
  .request_word(request_word), .request_valid(request_valid),
  .spi_error_pulse(spi_error_pulse),
  .spi_error_sticky_flag(spi_error_sticky_flag));
`default_nettype wire

// >>> spi_master_model.sv
/* Behavioural SPI master driving the slave phy link pins.
   Assumes pull-ups on clock, data and select; 48 ns link period. */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Master model
// ------------------------------------------------------------
module spi_master_model (
  output logic spi_clk,
  output logic chip_select_low,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en
);
  wire logic sdo_pin = serial_out_en ? serial_out : 1'bz;
  // Idle levels are the pull-up levels
  initial begin
    spi_clk = 1'b1;
    chip_select_low = 1'b1;
    serial_in = 1'b1;
  end
  // Frame of n bits, MSB first, answer bits collected into rx
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    rx = '0;
    #13;
    chip_select_low = 1'b0;
    serial_in = tx[n-1];
    #240;
    for (int i = n - 1; i >= 0; i--) begin
      if (i < n - 1)
        rx = {rx[30:0], sdo_pin};
      spi_clk = 1'b0;
      #24 spi_clk = 1'b1;
      serial_in = (i > 0) ? tx[i-1] : 1'b1;
      #24;
    end
    rx = {rx[30:0], sdo_pin};
    chip_select_low = 1'b1;
  endtask
  // Select dip too short for the select filter
  task automatic blip(input int t);
    #13;
    chip_select_low = 1'b0;
    #(t);
    chip_select_low = 1'b1;
  endtask
endmodule // spi_master_model
`default_nettype wire

// >>> spi_slave_physical_layer_tb_top.sv
/* Self-checking bench for the SPI slave phy.
   Assumes the master model in its own file and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module spi_slave_physical_layer_tb_top import spi_phy_pkg::*;;
  logic clk_sys, sys_rst, parity_check_enable, answer_valid, error_clear;
  logic [14:0] answer_payload, status_payload;
  wire logic spi_clk, chip_select_low, serial_in, serial_out, serial_out_en;
  wire logic [15:0] request_word;
  wire logic request_valid, spi_error_pulse, spi_error_sticky_flag;
  int err_count, total_checks, cyc;
  logic [31:0] rx;
  logic v, e;
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  spi_slave_phy i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .spi_clk(spi_clk), .chip_select_low(chip_select_low),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .parity_check_enable(parity_check_enable),
    .answer_payload(answer_payload), .answer_valid(answer_valid),
    .status_payload(status_payload), .error_clear(error_clear),
    .request_word(request_word), .request_valid(request_valid),
    .spi_error_pulse(spi_error_pulse),
    .spi_error_sticky_flag(spi_error_sticky_flag));
  spi_master_model i_mst (.spi_clk(spi_clk),
    .chip_select_low(chip_select_low), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en));
  function automatic logic [15:0] mk(input logic [14:0] p);
    return {p, ~^p};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, x);
    end
  endtask
  // Frame, then a fixed window that outlasts the result latency
  task automatic frame(input logic [31:0] tx, input int n);
    i_mst.xfer(tx, n, rx);
    v = 1'b0;
    e = 1'b0;
    repeat (20) begin
      @(negedge clk_sys);
      v = v | request_valid;
      e = e | spi_error_pulse;
    end
  endtask
  task automatic ans(input logic [14:0] p);
    @(posedge clk_sys);
    answer_payload <= p;
    answer_valid <= 1'b1;
    @(posedge clk_sys);
    answer_valid <= 1'b0;
  endtask
  task automatic t_basic;
    chk(serial_out_en, 0);
    frame(mk(15'h1234), 16);
    chk(rx[15:0], RESET_ANSWER);
    chk({v, e}, 2'b10);
    chk(request_word, mk(15'h1234));
    ans(15'h2AAA);
  endtask
  task automatic t_chain;
    frame({mk(15'h0F0F), mk(15'h7001)}, 32);
    chk(rx, {mk(15'h2AAA), mk(15'h0F0F)});
    chk(request_word, mk(15'h7001));
    ans(15'h5555);
  endtask
  task automatic t_parity;
    @(posedge clk_sys);
    parity_check_enable <= 1'b1;
    frame(mk(15'h0123) ^ 16'h0001, 16);
    chk(rx[15:0], mk(15'h5555));
    chk({v, e, spi_error_sticky_flag}, 3'b011);
    frame(mk(15'h0456), 16);
    chk(rx[15:0], mk(status_payload | 15'h4000));
    chk(v, 1);
    @(posedge clk_sys);
    error_clear <= 1'b1;
    @(posedge clk_sys);
    error_clear <= 1'b0;
    @(negedge clk_sys);
    chk(spi_error_sticky_flag, 0);
    @(posedge clk_sys);
    parity_check_enable <= 1'b0;
    frame(mk(15'h0321) ^ 16'h0001, 16);
    chk(v, 1);
  endtask
  task automatic t_count;
    frame(32'h0000_1111, 15);
    chk({v, e}, 2'b01);
    frame(32'h0001_2345, 17);
    chk({v, e}, 2'b01);
  endtask
  // Select blip shorter than two samples must not open a frame
  task automatic t_glitch;
    logic oe;
    oe = 1'b0;
    v = 1'b0;
    e = 1'b0;
    i_mst.blip(30);
    repeat (12) begin
      @(negedge clk_sys);
      oe = oe | serial_out_en;
      v = v | request_valid;
      e = e | spi_error_pulse;
    end
    chk({oe, v, e}, 3'b000);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim;
    end
  end
  initial begin
    sys_rst = 1'b0;
    parity_check_enable = 1'b0;
    answer_valid = 1'b0;
    error_clear = 1'b0;
    answer_payload = '0;
    // Bit 14 set so the forced notify bit must not upset parity
    status_payload = 15'h7C5A;
    // Reset rises on an edge so the link flops see a clean rise
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_basic;
    t_chain;
    t_parity;
    t_count;
    t_glitch;
    end_sim;
  end
endmodule // spi_slave_physical_layer_tb_top
`default_nettype wire
